// ---- hw/adc_conversion_control.sv ----
`timescale 1ns/1ps
module adc_conversion_control
   import adc_ctrl_pkg::*;
#(
   parameter int unsigned TIME_DIV = 1
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire bus_req_t                 bus,
   output logic [31:0]                   rdata,
   input  wire logic signed [FILT_W-1:0] filter_data,
   input  wire logic                     mod_overrange_pin,
   input  wire logic                     analog_overrange_pin,
   input  wire logic                     ext_clk_pin,
   output logic                          rdy_n,
   output logic                          adc_enable,
   output logic                          ext_clk_sel,
   output logic                          adc_powered_down
);
   typedef logic [PERIOD_W-1:0] per_tab_t [48];

   function automatic per_tab_t build_tab(input int unsigned div);
      per_tab_t        t;
      longint unsigned p;
      for (int i = 0; i < 48; i++) begin
         p = TICK_SCALE / RATE_TAB[i] / div;
         if (p < 1) begin
            p = 1;
         end
         t[i] = PERIOD_W'(p);
      end
      return t;
   endfunction : build_tab

   localparam per_tab_t PER_TAB = build_tab(TIME_DIV);

   ctrl_state_t         q;
   ctrl_state_t         d;
   logic [2:0]          pins_s;
   logic                tick;
   logic                due;
   logic                pub;
   logic [23:0]         pub_val;
   logic [PERIOD_W-1:0] period;
   logic signed [FILT_W-1:0] adj;
   logic [23:0]         sat_val;
   logic                cj_chan;
   logic                wr_cmd;
   logic                wr_gen;
   logic                rd_res;
   logic                rd_sta;
   logic [OSC_W:0]      osc_sum;
   logic [3:0]          wr_rate;
   logic                cal_off;
   logic [PERIOD_W-1:0] start_per;

   pin_sync3 #(.W(3)) u_sync (
      .clk   (clk),
      .rst   (rst),
      .pin   ({ext_clk_pin, analog_overrange_pin, mod_overrange_pin}),
      .level (pins_s)
   );

   assign wr_cmd = bus.wr && (bus.addr == OFS_CMD);
   assign wr_gen = bus.wr && (bus.addr == OFS_GEN);
   assign rd_res = bus.rd && (bus.addr == OFS_RESULT);
   assign rd_sta = bus.rd && (bus.addr == OFS_STATUS);
   assign osc_sum = {1'b0, q.osc} + {1'b0, OSC_STEP};

   always_comb begin
      d       = q;
      d.rdata = '0;
      tick    = 1'b0;
      due     = 1'b0;
      pub     = 1'b0;
      pub_val = '0;
      period  = '0;
      adj     = '0;
      sat_val = '0;
      cj_chan = (q.cfg.chan == CJ_A_CODE) || (q.cfg.chan == CJ_B_CODE);

      // ADC clock tick from internal oscillator model or external pin
      d.ext_prev = pins_s[2];
      if (q.cfg.ext_clk) begin
         tick = pins_s[2] && !q.ext_prev;
      end else if (osc_sum >= {1'b0, OSC_MOD}) begin
         tick  = 1'b1;
         d.osc = OSC_W'(osc_sum - {1'b0, OSC_MOD});
      end else begin
         d.osc = OSC_W'(osc_sum);
      end

      // Sample period lookup
      if (q.cfg.single_shot) begin
         if (q.cfg.gain_cal_dis && q.cfg.offset_cal_dis) begin
            period = PER_TAB[{2'h2, q.cfg.rate}];
         end else begin
            period = PER_TAB[{2'h1, q.cfg.rate}];
         end
      end else if (q.cfg.rate == RATE_TOP && !(q.cfg.gain_cal_dis && q.cfg.offset_cal_dis)) begin
         period = PER_TAB[{2'h0, RATE_HALF}];
      end else begin
         period = PER_TAB[{2'h0, q.cfg.rate}];
      end

      // First count of a start follows the rate written with it
      wr_rate = bus.wdata[CMD_RATE_LSB +: 4];
      cal_off = q.cfg.gain_cal_dis && q.cfg.offset_cal_dis;
      if (q.cfg.single_shot && cal_off) begin
         start_per = PER_TAB[{2'h2, wr_rate}];
      end else if (q.cfg.single_shot) begin
         start_per = PER_TAB[{2'h1, wr_rate}];
      end else if (wr_rate == RATE_TOP && !cal_off) begin
         start_per = PER_TAB[{2'h0, RATE_HALF}];
      end else begin
         start_per = PER_TAB[{2'h0, wr_rate}];
      end

      // Result coding and saturation
      adj = cj_chan ? (filter_data - CJ_OFS) : filter_data;
      if (adj > RES_MAX) begin
         sat_val = RES_MAX[23:0];
      end else if (adj < RES_MIN) begin
         sat_val = RES_MIN[23:0];
      end else begin
         sat_val = adj[23:0];
      end

      if (q.st != ST_IDLE && tick) begin
         if (q.cnt == '0) begin
            due   = 1'b1;
            d.cnt = period - PERIOD_W'(1);
         end else begin
            d.cnt = q.cnt - PERIOD_W'(1);
         end
      end

      // Early rise of ready before a result that overwrites an unread one
      if (q.pend) begin
         if (q.pre == '0) begin
            pub     = 1'b1;
            pub_val = q.pend_data;
            d.pend  = 1'b0;
         end else begin
            d.pre = q.pre - 5'h1;
         end
      end

      if (due) begin
         if (q.st == ST_RUN && !q.cfg.single_shot && q.settle != SETTLE_LAST) begin
            d.settle = q.settle + 3'h1;
         end else if (!q.rdy_n || q.pend) begin
            d.rdy_n     = 1'b1;
            d.pend      = 1'b1;
            d.pre       = RDY_PRE_LD;
            d.pend_data = sat_val;
            pub         = 1'b0;
         end else begin
            pub     = 1'b1;
            pub_val = sat_val;
         end
         if (q.st == ST_SHOT) begin
            d.st       = ST_IDLE;
            d.cfg.mode = MODE_STANDBY;
         end
      end

      if (rd_res && !q.rdy_n) begin
         d.rdy_n = 1'b1;
      end
      if (pub) begin
         d.result = pub_val;
         d.rdy_n  = 1'b0;
      end

      // Sticky overrange flags, a new event beats the read clear
      d.mor = (q.mor && !rd_sta) || pins_s[0];
      d.ana_ovr = (q.ana_ovr && !rd_sta) || pins_s[1];

      if (bus.wr) begin
         unique case (bus.addr)
            OFS_CMD: begin
               d.cfg.mode = bus.wdata[CMD_MODE_LSB +: 2];
               d.cfg.rate = bus.wdata[CMD_RATE_LSB +: 4];
            end
            OFS_CTRL_A: begin
               d.cfg.pd          = bus.wdata[CA_PD_BIT];
               d.cfg.single_shot = bus.wdata[CA_SS_BIT];
               d.cfg.repeat_shot = bus.wdata[CA_RSS_BIT];
            end
            OFS_CTRL_B: begin
               d.cfg.gain_cal_dis   = bus.wdata[CB_GCD_BIT];
               d.cfg.offset_cal_dis = bus.wdata[CB_OCD_BIT];
               d.cfg.ext_clk        = bus.wdata[CB_EXT_BIT];
            end
            OFS_GEN: begin
               d.cfg.chan = bus.wdata[GEN_SEL_LSB +: 4];
            end
            default: begin
            end
         endcase
      end

      if (wr_cmd) begin
         if (bus.wdata[CMD_MODE_LSB +: 2] == MODE_CONVERT) begin
            if (q.st == ST_IDLE) begin
               d.cnt    = start_per - PERIOD_W'(1);
               d.settle = '0;
               if (!q.cfg.single_shot) begin
                  d.st = ST_RUN;
               end else if (q.cfg.repeat_shot) begin
                  d.st = ST_RUN;
               end else begin
                  d.st = ST_SHOT;
               end
            end
         end else begin
            d.st   = ST_IDLE;
            d.pend = 1'b0;
            if (bus.wdata[CMD_MODE_LSB +: 2] == MODE_STANDBY && q.cfg.pd) begin
               d.result = '0;
               d.rdy_n  = 1'b1;
               d.settle = '0;
               d.cnt    = '0;
            end
         end
      end

      if (wr_gen && bus.wdata[GEN_SEL_LSB +: 4] != q.cfg.chan) begin
         d.st       = ST_IDLE;
         d.cfg.mode = MODE_STANDBY;
         d.pend     = 1'b0;
      end

      if (bus.rd) begin
         unique case (bus.addr)
            OFS_CMD:    d.rdata = {24'h0, q.cfg.rate, 2'h0, q.cfg.mode};
            OFS_CTRL_A: d.rdata = {29'h0, q.cfg.repeat_shot, q.cfg.single_shot, q.cfg.pd};
            OFS_CTRL_B: d.rdata = {29'h0, q.cfg.ext_clk, q.cfg.offset_cal_dis, q.cfg.gain_cal_dis};
            OFS_GEN:    d.rdata = {28'h0, q.cfg.chan};
            OFS_STATUS: begin
               d.rdata[ST_MOR_BIT]       = q.mor;
               d.rdata[ST_ANA_BIT]       = q.ana_ovr;
               d.rdata[ST_RUN_BIT]       = (q.st != ST_IDLE);
               d.rdata[ST_RDY_BIT]       = !q.rdy_n;
               d.rdata[ST_MODE_LSB +: 2] = q.cfg.mode;
               d.rdata[ST_RATE_LSB +: 4] = q.cfg.rate;
            end
            OFS_RESULT: d.rdata = {8'h0, q.result};
            default:    d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q          <= '0;
         q.cfg.mode <= MODE_STANDBY;
         q.cfg.rate <= RATE_RST;
         q.cfg.chan <= CHAN_RST;
         q.st       <= ST_IDLE;
         q.rdy_n    <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign rdata            = q.rdata;
   assign rdy_n            = q.rdy_n;
   assign adc_enable       = (q.st != ST_IDLE);
   assign ext_clk_sel      = q.cfg.ext_clk;
   assign adc_powered_down = (q.cfg.mode == MODE_STANDBY) && q.cfg.pd;

   mode_reset_a: assert property (@(posedge clk) rst |=> (q.cfg.mode == MODE_STANDBY && q.st == ST_IDLE))
      else $error("mode not standby after reset");

   sat_pos_a: assert property (@(posedge clk) disable iff (rst) (adj > RES_MAX) |-> (sat_val == 24'h7fffff))
      else $error("positive overflow not saturated");

   sat_neg_a: assert property (@(posedge clk) disable iff (rst) (adj < RES_MIN) |-> (sat_val == 24'h800000))
      else $error("negative overflow not saturated");

   stop_cmd_a: assert property (@(posedge clk) disable iff (rst)
      (wr_cmd && bus.wdata[1:0] == MODE_STANDBY) |=> (q.st == ST_IDLE && !adc_enable))
      else $error("standby write did not halt conversion");

   start_cmd_a: assert property (@(posedge clk) disable iff (rst)
      (wr_cmd && bus.wdata[1:0] == MODE_CONVERT && q.st == ST_IDLE && !wr_gen)
      |=> (q.st == (($past(q.cfg.single_shot) && !$past(q.cfg.repeat_shot)) ? ST_SHOT : ST_RUN)))
      else $error("start write did not enter the chosen mode");

   chan_halt_a: assert property (@(posedge clk) disable iff (rst)
      (wr_gen && bus.wdata[3:0] != q.cfg.chan) |=> (q.st == ST_IDLE && q.cfg.mode == MODE_STANDBY))
      else $error("channel change did not enter standby");

   rdy_fall_a: assert property (@(posedge clk) disable iff (rst) pub |=> (!rdy_n && q.result == $past(pub_val)))
      else $error("ready did not fall with new result");

   rdy_rise_a: assert property (@(posedge clk) disable iff (rst) (rd_res && !rdy_n && !pub) |=> rdy_n)
      else $error("ready did not rise after result read");

   settle_skip_a: assert property (@(posedge clk) disable iff (rst)
      (pub && q.st == ST_RUN && !q.cfg.single_shot && !q.pend) |-> (q.settle == SETTLE_LAST))
      else $error("result published before filter settled");

   shot_once_a: assert property (@(posedge clk) disable iff (rst) (q.st == ST_SHOT && due && !wr_cmd && !wr_gen)
      |=> (q.st == ST_IDLE) [*2])
      else $error("single shot did not stop after one conversion");

   flag_set_a: assert property (@(posedge clk) disable iff (rst) pins_s[0] |=> q.mor)
      else $error("modulator overrange flag lost");

   top_rate_a: assert property (@(posedge clk) disable iff (rst)
      (!q.cfg.single_shot && q.cfg.rate == RATE_TOP && !q.cfg.gain_cal_dis) |-> (period == PER_TAB[14]))
      else $error("top rate not limited with calibration on");

   top_rate_ocd_a: assert property (@(posedge clk) disable iff (rst)
      (!q.cfg.single_shot && q.cfg.rate == RATE_TOP && !q.cfg.offset_cal_dis) |-> (period == PER_TAB[14]))
      else $error("top rate not limited with offset calibration on");

   full_rate_a: assert property (@(posedge clk) disable iff (rst)
      (!q.cfg.single_shot && q.cfg.rate == RATE_TOP && cal_off) |-> (period == PER_TAB[15]))
      else $error("full rate not used with calibration off");

   ana_flag_a: assert property (@(posedge clk) disable iff (rst) pins_s[1] |=> q.ana_ovr)
      else $error("analog overrange flag lost");

   pd_clear_a: assert property (@(posedge clk) disable iff (rst)
      (wr_cmd && bus.wdata[CMD_MODE_LSB +: 2] == MODE_STANDBY && q.cfg.pd) |=> (q.result == 24'h0 && q.rdy_n))
      else $error("power-down write did not reset the converter");

   idle_hold_a: assert property (@(posedge clk) disable iff (rst)
      (q.st == ST_IDLE && !(wr_cmd && bus.wdata[CMD_MODE_LSB +: 2] == MODE_CONVERT)) |=> (q.st == ST_IDLE))
      else $error("conversion began without a start write");

   result_hold_a: assert property (@(posedge clk) disable iff (rst)
      (!pub && !wr_cmd) |=> (q.result == $past(q.result)))
      else $error("result changed without a new conversion");

   pre_high_a: assert property (@(posedge clk) disable iff (rst) (q.pend && !pub) |=> q.rdy_n)
      else $error("ready low while a result is pending");

   rss_publish_a: assert property (@(posedge clk) disable iff (rst)
      (due && q.st == ST_RUN && q.cfg.single_shot && q.rdy_n && !q.pend && !wr_cmd) |=> !rdy_n)
      else $error("repeat shot result not published at once");

   zero_code_a: assert property (@(posedge clk) disable iff (rst)
      (!cj_chan && filter_data == '0) |-> (sat_val == 24'h000000))
      else $error("zero input not coded as zero");

   cj_zero_a: assert property (@(posedge clk) disable iff (rst)
      (cj_chan && filter_data == CJ_OFS) |-> (sat_val == 24'h000000))
      else $error("cold junction mid input not coded as zero");

endmodule : adc_conversion_control

// ---- pkg/adc_ctrl_pkg.sv ----
// Contract
// - Modulator overrange sets a flag in the converter status register.
// - Filter overflow saturates result to 0x7fffff positive or 0x800000 negative.
// - Input beyond about 120% full scale sets the analog overrange flag.
// - Clock select bit picks external clock pin when 1, internal oscillator when 0.
// - Four-bit channel field selects one of eleven multiplexer sources.
// - Normal channels give two's complement results from 0x800000 to 0x7fffff.
// - Cold-junction inputs give offset coding: 0V 0x800000, 1.25V zero, 2.5V 0x7fffff.
// - Mode field resets to 01b, standby with no conversions.
// - Writing 01b stops conversion; with power-down bit high the converter resets.
// - Writing 11b starts one or continuous conversions per single-shot control bits.
// - Continuous mode discards the first four results while the filter settles.
// - Repeat single-shot mode streams samples with no settling latency.
// - Single-shot mode makes exactly one conversion per start command.
// - Writing 01b during either continuous mode halts conversions.
// - Changing the channel to another source halts conversion and enters standby.
// - Continuous rate codes map 0000b..1111b to 5 through 115200 samples per second.
// - The 115200 rate needs both calibration disable bits set by the host.
// - Repeat single-shot rates follow their own table, calibration dependent at upper codes.
// - Top continuous code with calibration enabled runs 57.6ksps; status keeps code.
// - Ready output falls on each new result, rises on result read while low.
package adc_ctrl_pkg;

   localparam int unsigned CLK_HZ      = 40_000_000;
   localparam int unsigned ADC_CLK_HZ  = 7_372_800;
   localparam int unsigned OSC_W       = 19;
   localparam logic [OSC_W-1:0] OSC_STEP = OSC_W'(ADC_CLK_HZ / 100);
   localparam logic [OSC_W-1:0] OSC_MOD  = OSC_W'(CLK_HZ / 100);
   localparam longint unsigned TICK_SCALE = 64'd10000 * ADC_CLK_HZ;
   localparam int unsigned PERIOD_W    = 24;

   localparam int unsigned RDY_PRE_NS  = 500;
   localparam int unsigned RDY_PRE_CYC = (RDY_PRE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [4:0]  RDY_PRE_LD  = 5'(RDY_PRE_CYC - 1);
   localparam logic [2:0]  SETTLE_LAST = 3'h4;

   localparam int unsigned ADDR_W      = 8;
   localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CTRL_A = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_GEN    = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h14;

   localparam int unsigned CMD_MODE_LSB = 0;
   localparam int unsigned CMD_RATE_LSB = 4;
   localparam int unsigned CA_PD_BIT    = 0;
   localparam int unsigned CA_SS_BIT    = 1;
   localparam int unsigned CA_RSS_BIT   = 2;
   localparam int unsigned CB_GCD_BIT   = 0;
   localparam int unsigned CB_OCD_BIT   = 1;
   localparam int unsigned CB_EXT_BIT   = 2;
   localparam int unsigned GEN_SEL_LSB  = 0;
   localparam int unsigned ST_MOR_BIT   = 0;
   localparam int unsigned ST_ANA_BIT   = 1;
   localparam int unsigned ST_RUN_BIT   = 2;
   localparam int unsigned ST_RDY_BIT   = 3;
   localparam int unsigned ST_MODE_LSB  = 4;
   localparam int unsigned ST_RATE_LSB  = 8;

   localparam logic [1:0] MODE_STANDBY = 2'h1;
   localparam logic [1:0] MODE_CONVERT = 2'h3;
   localparam logic [3:0] RATE_RST     = 4'h0;
   localparam logic [3:0] CHAN_RST     = 4'h0;
   localparam logic [3:0] CJ_A_CODE    = 4'h9;
   localparam logic [3:0] CJ_B_CODE    = 4'ha;
   localparam logic [3:0] RATE_TOP     = 4'hf;
   localparam logic [3:0] RATE_HALF    = 4'he;

   localparam int unsigned FILT_W = 26;
   localparam logic signed [FILT_W-1:0] RES_MAX = 26'sh07fffff;
   localparam logic signed [FILT_W-1:0] RES_MIN = -26'sh0800000;
   localparam logic signed [FILT_W-1:0] CJ_OFS  = 26'sh0800000;

   // Rates in units of 1e-4 sps: continuous, repeat shot with cal, without cal
   localparam int unsigned RATE_TAB [48] = '{
      50000, 100000, 150000, 300000, 500000, 600000, 2250000, 4500000, 9000000, 18000000,
      36000000, 72000000, 144000000, 288000000, 576000000, 1152000000,
      9955, 25000, 50000, 100000, 125000, 150000, 500000, 600000, 1500000, 2990000,
      8870000, 17550000, 27680000, 53270000, 99100000, 173890000,
      9955, 25000, 50000, 100000, 125000, 150000, 500000, 600000, 1500000, 2990000,
      8920000, 17760000, 28180000, 55190000, 105930000, 196090000};

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_SHOT = 3'b100
   } conv_state_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
   } bus_req_t;

   typedef struct packed {
      logic [1:0] mode;
      logic [3:0] rate;
      logic       pd;
      logic       single_shot;
      logic       repeat_shot;
      logic       gain_cal_dis;
      logic       offset_cal_dis;
      logic       ext_clk;
      logic [3:0] chan;
   } cfg_t;

   typedef struct packed {
      cfg_t                cfg;
      conv_state_t         st;
      logic [OSC_W-1:0]    osc;
      logic                ext_prev;
      logic [PERIOD_W-1:0] cnt;
      logic [2:0]          settle;
      logic                pend;
      logic [4:0]          pre;
      logic [23:0]         pend_data;
      logic [23:0]         result;
      logic                rdy_n;
      logic                mor;
      logic                ana_ovr;
      logic [31:0]         rdata;
   } ctrl_state_t;

endpackage : adc_ctrl_pkg

// ---- hw/pin_sync3.sv ----
`timescale 1ns/1ps
module pin_sync3 #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } sync_t;

   sync_t q;
   sync_t d;

   always_comb begin
      d    = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < W; i++) begin
         // Output moves only when the last two stages agree
         if (q.s2[i] == q.s3[i]) begin
            d.o[i] = q.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level = q.o;

endmodule : pin_sync3

// ---- verification/adc_front_model.sv ----
`timescale 1ns/1ps
module adc_front_model
   import adc_ctrl_pkg::*;
(
   input  wire logic                     ext_run,
   input  wire logic signed [FILT_W-1:0] level,
   input  wire logic                     mor,
   input  wire logic                     ana_ovr,
   output logic signed [FILT_W-1:0]      filter_data,
   output logic                          mod_overrange_pin,
   output logic                          analog_overrange_pin,
   output logic                          ext_clk_pin
);
   assign filter_data          = level;
   assign mod_overrange_pin    = mor;
   assign analog_overrange_pin = ana_ovr;
   // 7.3728 MHz source, held low while unused
   initial begin
      ext_clk_pin = 1'b0;
      forever begin
         #67.817;
         ext_clk_pin = ext_run ? ~ext_clk_pin : 1'b0;
      end
   end
endmodule : adc_front_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench
   import adc_ctrl_pkg::*;
;
   logic                     clk;
   logic                     rst;
   bus_req_t                 bus;
   logic [31:0]              rdata;
   logic signed [FILT_W-1:0] level;
   logic                     mor;
   logic                     ana_ovr;
   logic                     ext_run;
   logic signed [FILT_W-1:0] filter_data;
   logic                     mpin;
   logic                     apin;
   logic                     xpin;
   logic                     rdy_n;
   logic                     adc_enable;
   logic                     ext_clk_sel;
   logic                     adc_powered_down;
   logic [31:0]              d;
   int                       bad_count;
   int                       compares;

   adc_conversion_control #(.TIME_DIV(1)) u_adc_conversion_control (
      .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .filter_data(filter_data),
      .mod_overrange_pin(mpin), .analog_overrange_pin(apin), .ext_clk_pin(xpin),
      .rdy_n(rdy_n), .adc_enable(adc_enable), .ext_clk_sel(ext_clk_sel),
      .adc_powered_down(adc_powered_down));

   adc_front_model u_adc_front_model (
      .ext_run(ext_run), .level(level), .mor(mor), .ana_ovr(ana_ovr), .filter_data(filter_data),
      .mod_overrange_pin(mpin), .analog_overrange_pin(apin), .ext_clk_pin(xpin));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic conclude;
      if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t pin %b expected %b", $time, got, exp);
      end
   endtask : chk1

   task automatic chk_rng(input int n, input int lo, input int hi);
      compares++;
      if (n < lo || n > hi) begin
         bad_count++;
         $display("[FAIL] %0t delay %0d outside %0d..%0d", $time, n, lo, hi);
      end
   endtask : chk_rng

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      bus.wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd

   // Bounded wait for ready to reach a level
   task automatic wait_lvl(input logic v, output int n);
      n = 0;
      while (rdy_n !== v) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 20000) begin
            bad_count++;
            $display("[FAIL] %0t ready wait expired", $time);
            conclude();
         end
      end
   endtask : wait_lvl

   task automatic t_reset;
      rd(OFS_CMD, d);
      chk32(d, 32'h1);
      rd(OFS_STATUS, d);
      chk32(d, 32'h10);
      rd(8'h18, d);
      chk32(d, 32'h0);
      chk1(rdy_n, 1'b1);
      chk1(adc_enable, 1'b0);
      chk1(adc_powered_down, 1'b0);
      chk1(ext_clk_sel, 1'b0);
   endtask : t_reset

   task automatic t_shot(input logic [3:0] ch, input logic signed [FILT_W-1:0] v, input logic [23:0] e);
      int n;
      @(posedge clk);
      level <= v;
      wr(OFS_GEN, {28'h0, ch});
      wr(OFS_CTRL_B, 32'h3);
      wr(OFS_CTRL_A, 32'h2);
      wr(OFS_CMD, 32'hf3);
      chk1(adc_enable, 1'b1);
      wait_lvl(1'b0, n);
      chk1(adc_enable, 1'b0);
      rd(OFS_RESULT, d);
      chk32(d, {8'h0, e});
      chk1(rdy_n, 1'b1);
      rd(OFS_CMD, d);
      chk32(d, 32'hf1);
   endtask : t_shot

   task automatic t_cont(input logic [31:0] cb, input int lo, input int hi);
      int n;
      wr(OFS_CTRL_B, cb);
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_CMD, 32'hf3);
      wait_lvl(1'b0, n);
      chk_rng(n, lo, hi);
      rd(OFS_STATUS, d);
      chk32(d & 32'hf00, 32'hf00);
      chk1(adc_enable, 1'b1);
      wr(OFS_CMD, 32'h1);
      chk1(adc_enable, 1'b0);
      rd(OFS_RESULT, d);
      chk32(d, 32'h007fffff);
      chk1(rdy_n, 1'b1);
   endtask : t_cont

   task automatic t_pd;
      wr(OFS_CTRL_A, 32'h1);
      wr(OFS_CMD, 32'h1);
      chk1(adc_powered_down, 1'b1);
      rd(OFS_RESULT, d);
      chk32(d, 32'h0);
      wr(OFS_CTRL_A, 32'h0);
      chk1(adc_powered_down, 1'b0);
   endtask : t_pd

   task automatic t_rss;
      int n;
      wr(OFS_CTRL_B, 32'h3);
      wr(OFS_CTRL_A, 32'h6);
      wr(OFS_CMD, 32'hf3);
      wait_lvl(1'b0, n);
      chk_rng(n, 1900, 2200);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
      chk_rng(n, RDY_PRE_CYC - 1, RDY_PRE_CYC + 1);
      chk1(adc_enable, 1'b1);
      rd(OFS_RESULT, d);
      chk32(d, 32'h007fffff);
      chk1(rdy_n, 1'b1);
      wr(OFS_GEN, 32'h0);
      chk1(adc_enable, 1'b0);
      rd(OFS_CMD, d);
      chk32(d & 32'h3, 32'h1);
   endtask : t_rss

   task automatic t_ovr;
      @(posedge clk);
      mor <= 1'b1;
      ana_ovr <= 1'b1;
      repeat (8) @(posedge clk);
      rd(OFS_STATUS, d);
      chk32(d & 32'h3, 32'h3);
      @(posedge clk);
      mor <= 1'b0;
      ana_ovr <= 1'b0;
      repeat (8) @(posedge clk);
      rd(OFS_STATUS, d);
      rd(OFS_STATUS, d);
      chk32(d & 32'h3, 32'h0);
   endtask : t_ovr

   task automatic t_ext;
      int n;
      wr(OFS_CTRL_B, 32'h7);
      chk1(ext_clk_sel, 1'b1);
      @(posedge clk);
      ext_run <= 1'b1;
      wr(OFS_CTRL_A, 32'h2);
      wr(OFS_CMD, 32'hf3);
      wait_lvl(1'b0, n);
      chk_rng(n, 1900, 2200);
      rd(OFS_RESULT, d);
      chk32(d, 32'h007fffff);
      @(posedge clk);
      ext_run <= 1'b0;
      wr(OFS_CTRL_B, 32'h3);
      chk1(ext_clk_sel, 1'b0);
   endtask : t_ext

   initial begin
      bad_count = 0;
      compares = 0;
      rst = 1'b1;
      bus = '0;
      level = '0;
      mor = 1'b0;
      ana_ovr = 1'b0;
      ext_run = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_shot(4'h0, 26'sh0000123, 24'h000123);
      t_shot(4'h5, -26'sh0000001, 24'hffffff);
      t_shot(4'h0, 26'sh0900000, 24'h7fffff);
      t_shot(4'h0, -26'sh0900000, 24'h800000);
      t_shot(CJ_A_CODE, 26'sh0000000, 24'h800000);
      t_shot(CJ_B_CODE, 26'sh0800000, 24'h000000);
      t_shot(CJ_B_CODE, 26'sh0ffffff, 24'h7fffff);
      t_cont(32'h3, 1600, 1900);
      t_pd();
      t_cont(32'h0, 3300, 3650);
      t_ovr();
      t_ext();
      t_rss();
      conclude();
   end
endmodule : testbench
